//--- epv_regs.svh
// Constants of the exception priority and vector unit
`ifndef EPV_REGS_SVH
`define EPV_REGS_SVH
`define EPV_VEC_RESET 8'h00
`define EPV_VEC_ILLEGAL 8'h04
`define EPV_VEC_TRACE 8'h05
`define EPV_VEC_NMI 8'h07
`define EPV_VEC_TRAP0 8'h08
`define EPV_VEC_CPU_AERR 8'h0C
`define EPV_VEC_DMA_AERR 8'h0D
`define EPV_VEC_IRQ_FIRST 8'h40
`define EPV_VEC_IRQ_LAST 8'h4F
`define EPV_VEC_INT_FIRST 8'h51
`define EPV_VEC_SHIFT 2
`define EPV_OFFSET_BITS 16
`define EPV_ADDR_BITS 24
`define EPV_MODE_USER_BOOT 3'h1
`define EPV_MODE_BOOT 3'h2
`define EPV_MODE_ADV 3'h3
`define EPV_ICM_RESET 2'h0
`define EPV_ICM_TRACE 2'h2
`define EPV_VBR_RESET 32'h00000000
`define EPV_EXR_MASK_SET 3'h7
`define EPV_RES_MIN_CYC 20
`endif

//--- epv_pkg.sv
// Types and decode functions of the exception priority and vector unit
`include "epv_regs.svh"
package epv_pkg;
  typedef enum logic [2:0] {
    ST_RESET = 3'h0,
    ST_RUN = 3'h1,
    ST_STACK = 3'h2,
    ST_FETCH = 3'h3,
    ST_LOAD = 3'h4
  } epv_state_t;

  typedef enum logic [2:0] {
    SRC_NONE = 3'h0,
    SRC_RESET = 3'h1,
    SRC_ILLEGAL = 3'h2,
    SRC_TRACE = 3'h3,
    SRC_AERR = 3'h4,
    SRC_IRQ = 3'h5,
    SRC_TRAP = 3'h6
  } epv_src_t;

  // Vectors fetched relative to the vector base
  function automatic logic vec_uses_base(input logic [7:0] v);
    return !(v == `EPV_VEC_RESET || v == `EPV_VEC_CPU_AERR);
  endfunction

  // Vectors that an interrupt request may carry
  function automatic logic vec_is_int(input logic [7:0] v);
    return (v == `EPV_VEC_NMI) || (v >= `EPV_VEC_IRQ_FIRST && v <= `EPV_VEC_IRQ_LAST)
      || (v >= `EPV_VEC_INT_FIRST);
  endfunction
endpackage

//--- epv_vec_addr.sv
// Vector table address from vector number and vector base
`include "epv_regs.svh"
module epv_vec_addr #(
  parameter int ADDR_BITS = `EPV_ADDR_BITS
) (
  // Vector selection
  input wire logic [7:0] vec_num_i,
  input wire logic [31:0] vector_base_i,
  // Table address
  output logic [ADDR_BITS-1:0] addr_o
);
  logic [`EPV_OFFSET_BITS-1:0] offset;
  logic [31:0] full;

  // Four bytes per entry, offset is the low half of the address
  always_comb
  begin
    offset = {6'h00, vec_num_i, 2'h0};
    if (epv_pkg::vec_uses_base(vec_num_i))
      full = vector_base_i + {16'h0000, offset};
    else
      full = {16'h0000, offset};
    addr_o = full[ADDR_BITS-1:0];
  end
endmodule

//--- epv_unit.sv
// Exception priority selection, vector fetch and mode decode
`include "epv_regs.svh"
// What this block does
// - Mode 1 is user boot; otherwise behaves like mode 3.
// - Mode 2 is flash boot; otherwise behaves like mode 3.
// - Mode 3: advanced 16 Mbyte addressing, single chip, on-chip ROM on.
// - Fixed priority: reset, illegal, trace, address error, interrupt, trap.
// - Held in reset while pin low; reset handling on release or watchdog.
// - Undefined instruction code raises the illegal instruction exception.
// - Trace after each completion when single-step set and control mode 2.
// - No trace after the return-from-handler instruction.
// - CPU address error handling waits until the current instruction completes.
// - Pending interrupt taken when the current instruction completes.
// - No interrupt sampling after flag-changing instructions or reset handling.
// - Software trap always accepted in program execution.
// - Reset and CPU address error use offset alone; others add vector base.
// - Each source has its own vector number; reserved numbers never used.
// - Four-byte entries at four times vector number, low 16 address bits.
// - DMA address error comes from transfer controllers, not CPU accesses.
// - Handler address read from the table and handed to program counter.
// - Reset pin low halts everything at once, above any exception.
// - Watchdog overflow resets the whole chip like the reset pin.
// - Reset initialises CPU and peripherals; interrupt control mode becomes 0.
// - Reset clears vector base and single-step, sets all mask bits.
// - After reset all interrupts blocked until the stack pointer is set.
// - Address error saves program counter and both status words first.
module epv_unit #(
  parameter int ADDR_BITS = `EPV_ADDR_BITS
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic wdt_overflow_i,
  input wire logic [2:0] mode_i,
  // Sequencer events
  input wire logic instr_done_i,
  input wire logic instr_rte_i,
  input wire logic flag_and_instr_i,
  input wire logic flag_or_instr_i,
  input wire logic flag_xor_instr_i,
  input wire logic flag_load_instr_i,
  input wire logic undef_instr_i,
  input wire logic trap_i,
  input wire logic [1:0] trap_num_i,
  input wire logic cpu_addr_err_i,
  input wire logic sp_set_i,
  // Transfer controller faults
  input wire logic data_transfer_ctrl_err_i,
  input wire logic dmac_err_i,
  // Interrupt controller
  input wire logic irq_req_i,
  input wire logic [7:0] irq_vec_i,
  // Status writes
  input wire logic vbr_wr_i,
  input wire logic [31:0] vbr_data_i,
  input wire logic exr_wr_i,
  input wire logic exr_t_i,
  input wire logic [2:0] exr_mask_i,
  input wire logic ccr_wr_i,
  input wire logic ccr_mask_i,
  input wire logic icm_wr_i,
  input wire logic [1:0] icm_i,
  // Stacking and vector fetch
  input wire logic stack_done_i,
  input wire logic fetch_ack_i,
  input wire logic [31:0] fetch_data_i,
  output logic stack_req_o,
  output logic fetch_req_o,
  output logic [ADDR_BITS-1:0] fetch_addr_o,
  output logic pc_load_o,
  output logic [31:0] pc_value_o,
  // Exception status
  output logic chip_reset_o,
  output logic busy_o,
  output logic [2:0] src_o,
  output logic [7:0] vec_num_o,
  output logic irq_blocked_o,
  output logic [31:0] vector_base_o,
  output logic trace_bit_o,
  output logic [2:0] exr_mask_o,
  output logic ccr_mask_o,
  output logic [1:0] icm_o,
  // Operating mode
  output logic user_boot_o,
  output logic flash_boot_o,
  output logic advanced_o,
  output logic single_chip_o,
  output logic rom_enable_o,
  output logic mode_bad_o
);
  logic rst_meta_q;
  logic rst_n_q;
  epv_pkg::epv_state_t state_q, state_d;
  epv_pkg::epv_src_t src_q, src_d;
  logic [2:0] mode_q, mode_d;
  logic [1:0] icm_q, icm_d;
  logic [31:0] vbr_q, vbr_d;
  logic exr_t_q, exr_t_d;
  logic [2:0] exr_mask_q, exr_mask_d;
  logic ccr_mask_q, ccr_mask_d;
  logic irq_block_q, irq_block_d;
  logic ill_q, ill_d, trc_q, trc_d, aseen_q, aseen_d, aerr_q, aerr_d;
  logic dma_q, dma_d, irq_q, irq_d, trap_q, trap_d;
  logic [7:0] irqv_q, irqv_d, vec_q, vec_d;
  logic [1:0] trapn_q, trapn_d;
  logic [ADDR_BITS-1:0] fetch_addr_q, fetch_addr_d, calc_addr;
  logic [31:0] pc_q, pc_d;
  logic wdt_q;
  logic run;
  logic flag_any;

  // Reset release through two flip-flops; pin low acts at once
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  epv_vec_addr #(.ADDR_BITS(ADDR_BITS)) u_vec_addr (
    .vec_num_i(vec_q),
    .vector_base_i(vbr_q),
    .addr_o(calc_addr)
  );

  assign run = (state_q == epv_pkg::ST_RUN);
  assign flag_any = flag_and_instr_i | flag_or_instr_i | flag_xor_instr_i | flag_load_instr_i;

  // Next state: pending events, priority pick, vector sequence
  always_comb
  begin
    state_d = state_q;
    src_d = src_q;
    mode_d = mode_q;
    icm_d = icm_q;
    vbr_d = vbr_q;
    exr_t_d = exr_t_q;
    exr_mask_d = exr_mask_q;
    ccr_mask_d = ccr_mask_q;
    irq_block_d = irq_block_q;
    ill_d = ill_q;
    trc_d = trc_q;
    aseen_d = aseen_q;
    aerr_d = aerr_q;
    dma_d = dma_q;
    irq_d = irq_q;
    irqv_d = irqv_q;
    trap_d = trap_q;
    trapn_d = trapn_q;
    vec_d = vec_q;
    fetch_addr_d = fetch_addr_q;
    pc_d = pc_q;
    // Software writes to status state
    if (vbr_wr_i)
      vbr_d = vbr_data_i;
    if (exr_wr_i)
    begin
      exr_t_d = exr_t_i;
      exr_mask_d = exr_mask_i;
    end
    if (ccr_wr_i)
      ccr_mask_d = ccr_mask_i;
    if (icm_wr_i)
      icm_d = icm_i;
    if (sp_set_i)
      irq_block_d = 1'b0;
    unique case (state_q)
      epv_pkg::ST_RESET:
      begin
        mode_d = mode_i;
        src_d = epv_pkg::SRC_RESET;
        vec_d = `EPV_VEC_RESET;
        fetch_addr_d = calc_addr;
        state_d = epv_pkg::ST_FETCH;
      end
      epv_pkg::ST_RUN:
      begin
        if (ill_q || trc_q || aerr_q || dma_q || irq_q || trap_q)
        begin
          state_d = epv_pkg::ST_STACK;
          exr_t_d = 1'b0;
          ccr_mask_d = 1'b1;
          // Fixed order, highest first
          if (ill_q)
          begin
            ill_d = 1'b0;
            src_d = epv_pkg::SRC_ILLEGAL;
            vec_d = `EPV_VEC_ILLEGAL;
          end
          else if (trc_q)
          begin
            trc_d = 1'b0;
            src_d = epv_pkg::SRC_TRACE;
            vec_d = `EPV_VEC_TRACE;
          end
          else if (aerr_q)
          begin
            aerr_d = 1'b0;
            src_d = epv_pkg::SRC_AERR;
            vec_d = `EPV_VEC_CPU_AERR;
          end
          else if (dma_q)
          begin
            dma_d = 1'b0;
            src_d = epv_pkg::SRC_AERR;
            vec_d = `EPV_VEC_DMA_AERR;
          end
          else if (irq_q)
          begin
            irq_d = 1'b0;
            src_d = epv_pkg::SRC_IRQ;
            vec_d = irqv_q;
          end
          else
          begin
            trap_d = 1'b0;
            src_d = epv_pkg::SRC_TRAP;
            vec_d = `EPV_VEC_TRAP0 + {6'h00, trapn_q};
          end
        end
      end
      epv_pkg::ST_STACK:
      begin
        if (stack_done_i)
        begin
          fetch_addr_d = calc_addr;
          state_d = epv_pkg::ST_FETCH;
        end
      end
      epv_pkg::ST_FETCH:
      begin
        if (fetch_ack_i)
        begin
          pc_d = fetch_data_i;
          state_d = epv_pkg::ST_LOAD;
        end
      end
      epv_pkg::ST_LOAD:
        state_d = epv_pkg::ST_RUN;
      default:
        state_d = epv_pkg::ST_RESET;
    endcase
    // New events after the pick so that a set wins over the clear
    if (run && undef_instr_i)
      ill_d = 1'b1;
    if (run && instr_done_i && exr_t_q && icm_q == `EPV_ICM_TRACE && !instr_rte_i)
      trc_d = 1'b1;
    if (run && cpu_addr_err_i)
      aseen_d = 1'b1;
    if (run && instr_done_i && (aseen_q || cpu_addr_err_i))
    begin
      aseen_d = 1'b0;
      aerr_d = 1'b1;
    end
    if (data_transfer_ctrl_err_i || dmac_err_i)
      dma_d = 1'b1;
    if (run && instr_done_i && irq_req_i && !flag_any && !irq_block_q
        && epv_pkg::vec_is_int(irq_vec_i) && !irq_q)
    begin
      irq_d = 1'b1;
      irqv_d = irq_vec_i;
    end
    if (trap_i && state_q != epv_pkg::ST_RESET && !trap_q)
    begin
      trap_d = 1'b1;
      trapn_d = trap_num_i;
    end
    // Watchdog overflow restarts everything as a pin reset would
    if (wdt_overflow_i)
    begin
      state_d = epv_pkg::ST_RESET;
      src_d = epv_pkg::SRC_NONE;
      mode_d = 3'h0;
      icm_d = `EPV_ICM_RESET;
      vbr_d = `EPV_VBR_RESET;
      exr_t_d = 1'b0;
      exr_mask_d = `EPV_EXR_MASK_SET;
      ccr_mask_d = 1'b1;
      irq_block_d = 1'b1;
      {ill_d, trc_d, aseen_d, aerr_d, dma_d, irq_d, trap_d} = 7'h00;
      irqv_d = 8'h00;
      trapn_d = 2'h0;
      vec_d = `EPV_VEC_RESET;
      fetch_addr_d = '0;
      pc_d = 32'h00000000;
    end
  end

  // Register all state; reset values match the watchdog path
  always_ff @(posedge clock_i or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q <= epv_pkg::ST_RESET;
      src_q <= epv_pkg::SRC_NONE;
      mode_q <= 3'h0;
      icm_q <= `EPV_ICM_RESET;
      vbr_q <= `EPV_VBR_RESET;
      exr_t_q <= 1'b0;
      exr_mask_q <= `EPV_EXR_MASK_SET;
      ccr_mask_q <= 1'b1;
      irq_block_q <= 1'b1;
      {ill_q, trc_q, aseen_q, aerr_q, dma_q, irq_q, trap_q} <= 7'h00;
      irqv_q <= 8'h00;
      trapn_q <= 2'h0;
      vec_q <= `EPV_VEC_RESET;
      fetch_addr_q <= '0;
      pc_q <= 32'h00000000;
      wdt_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      src_q <= src_d;
      mode_q <= mode_d;
      icm_q <= icm_d;
      vbr_q <= vbr_d;
      exr_t_q <= exr_t_d;
      exr_mask_q <= exr_mask_d;
      ccr_mask_q <= ccr_mask_d;
      irq_block_q <= irq_block_d;
      {ill_q, trc_q, aseen_q, aerr_q, dma_q, irq_q, trap_q}
        <= {ill_d, trc_d, aseen_d, aerr_d, dma_d, irq_d, trap_d};
      irqv_q <= irqv_d;
      trapn_q <= trapn_d;
      vec_q <= vec_d;
      fetch_addr_q <= fetch_addr_d;
      pc_q <= pc_d;
      wdt_q <= wdt_overflow_i;
    end
  end

  // Handshakes and status outputs
  assign chip_reset_o = !rst_n_q || wdt_q;
  assign stack_req_o = (state_q == epv_pkg::ST_STACK);
  assign fetch_req_o = (state_q == epv_pkg::ST_FETCH);
  assign pc_load_o = (state_q == epv_pkg::ST_LOAD);
  assign busy_o = !run;
  assign fetch_addr_o = fetch_addr_q;
  assign pc_value_o = pc_q;
  assign src_o = src_q;
  assign vec_num_o = vec_q;
  assign irq_blocked_o = irq_block_q;
  assign vector_base_o = vbr_q;
  assign trace_bit_o = exr_t_q;
  assign exr_mask_o = exr_mask_q;
  assign ccr_mask_o = ccr_mask_q;
  assign icm_o = icm_q;

  // Mode decode; modes 1 and 2 otherwise run as mode 3
  assign user_boot_o = (mode_q == `EPV_MODE_USER_BOOT);
  assign flash_boot_o = (mode_q == `EPV_MODE_BOOT);
  assign advanced_o = (mode_q >= `EPV_MODE_USER_BOOT) && (mode_q <= `EPV_MODE_ADV);
  assign single_chip_o = advanced_o;
  assign rom_enable_o = advanced_o;
  assign mode_bad_o = !advanced_o && (state_q != epv_pkg::ST_RESET);

  // Checks on priority, timing and vector formation
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_q);

  property p_prio;
    run && ill_q && !wdt_overflow_i |=> vec_q == `EPV_VEC_ILLEGAL && state_q == epv_pkg::ST_STACK;
  endproperty
  a_prio: assert property (p_prio) else $error("illegal not given top priority");

  property p_trace;
    run && instr_done_i && exr_t_q && icm_q == `EPV_ICM_TRACE && !instr_rte_i
      && !wdt_overflow_i |=> trc_q;
  endproperty
  a_trace: assert property (p_trace) else $error("trace not armed");

  property p_no_trace_rte;
    !trc_q && instr_done_i && instr_rte_i && !wdt_overflow_i |=> !trc_q;
  endproperty
  a_no_trace_rte: assert property (p_no_trace_rte) else $error("trace after return");

  property p_aerr_defer;
    $rose(aerr_q) |-> $past(instr_done_i);
  endproperty
  a_aerr_defer: assert property (p_aerr_defer) else $error("address error not deferred");

  property p_flag_noirq;
    run && instr_done_i && flag_any && !irq_q |=> !irq_q;
  endproperty
  a_flag_noirq: assert property (p_flag_noirq) else $error("interrupt sampled after flag op");

  property p_irq_block;
    irq_block_q |-> !irq_q;
  endproperty
  a_irq_block: assert property (p_irq_block) else $error("interrupt before stack set");

  property p_no_base;
    state_q == epv_pkg::ST_FETCH && !epv_pkg::vec_uses_base(vec_q)
      |-> fetch_addr_q == ADDR_BITS'({vec_q, 2'h0});
  endproperty
  a_no_base: assert property (p_no_base) else $error("offset-only vector wrong");

  property p_pc_load;
    state_q == epv_pkg::ST_FETCH && fetch_ack_i && !wdt_overflow_i
      |=> pc_load_o && pc_value_o == $past(fetch_data_i) ##1 !pc_load_o;
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("handler address not loaded");

  property p_vec_stable;
    state_q == epv_pkg::ST_FETCH && !fetch_ack_i && !wdt_overflow_i
      |=> $stable(vec_num_o) && fetch_req_o;
  endproperty
  a_vec_stable: assert property (p_vec_stable) else $error("vector moved during fetch");

  property p_reset_init;
    state_q == epv_pkg::ST_RESET |-> vbr_q == `EPV_VBR_RESET && !exr_t_q && ccr_mask_q
      && exr_mask_q == `EPV_EXR_MASK_SET && icm_q == `EPV_ICM_RESET;
  endproperty
  a_reset_init: assert property (p_reset_init) else $error("reset state not initialised");

  property p_stack_first;
    state_q == epv_pkg::ST_STACK |=> state_q == epv_pkg::ST_STACK || $past(stack_done_i)
      || state_q == epv_pkg::ST_RESET;
  endproperty
  a_stack_first: assert property (p_stack_first) else $error("vectored before stacking");

  c_reset_fetch: cover property (state_q == epv_pkg::ST_RESET ##1 fetch_req_o [*2] ##1 pc_load_o);
  c_irq: cover property (run && irq_q ##1 src_o == epv_pkg::SRC_IRQ);
  c_trace: cover property (trc_q && run ##1 vec_num_o == `EPV_VEC_TRACE);
  c_trap: cover property (trap_q && run ##1 src_o == epv_pkg::SRC_TRAP);
endmodule

//--- epv_seq_model.sv
// Model of the sequencer side: stacking and vector table memory
module epv_seq_model (
  // Clock, reset and answer delay
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic [3:0] wait_i,
  // Requests from the unit
  input wire logic stack_req_i,
  input wire logic fetch_req_i,
  input wire logic [23:0] fetch_addr_i,
  // Answers
  output logic stack_done_o,
  output logic fetch_ack_o,
  output logic [31:0] fetch_data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // One answer pulse per request after wait_i idle cycles
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_q <= 4'h0;
      stack_done_o <= 1'b0;
      fetch_ack_o <= 1'b0;
      fetch_data_o <= 32'h5A5A5A5A;
    end
    else
    begin
      stack_done_o <= 1'b0;
      fetch_ack_o <= 1'b0;
      fetch_data_o <= ~fetch_data_o; // Data not held outside the ack
      if ((stack_req_i || fetch_req_i) && !stack_done_o && !fetch_ack_o)
      begin
        if (cnt_q == wait_i)
        begin
          cnt_q <= 4'h0;
          stack_done_o <= stack_req_i;
          fetch_ack_o <= fetch_req_i;
          if (fetch_req_i)
            fetch_data_o <= {8'hC3, fetch_addr_i};
        end
        else
          cnt_q <= cnt_q + 4'h1;
      end
      else
        cnt_q <= 4'h0;
    end
  end
endmodule

//--- tb_top.sv
// Self-checking testbench of the exception priority and vector unit
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wdt = 1'b0;
  logic [2:0] mode = 3'h3;
  logic [11:0] ev = 12'h000;
  logic [1:0] tnum = 2'h0;
  logic irq = 1'b0;
  logic [7:0] ivec = 8'h00;
  logic cfg_wr = 1'b0;
  logic [31:0] vb = 32'h0;
  logic t_bit = 1'b0;
  logic [1:0] icm = 2'h0;
  logic [3:0] dly = 4'h0;
  logic stack_done, fetch_ack, stack_req, fetch_req, pc_load, chip_reset, busy;
  logic [31:0] fetch_data, pc_value, vbase;
  logic [23:0] faddr;
  logic [2:0] src, exr_mask;
  logic [7:0] vec_num;
  logic blocked, t_out, ccr_mask, ub, fb, adv, sc, rom, bad;
  logic [1:0] icm_out;
  int error_cnt = 0;
  int checks = 0;
  logic [7:0] irq_vecs [5] = '{8'h40, 8'h07, 8'h4F, 8'h51, 8'hFF};
  // Clock of 25 ns
  initial
  begin
    forever #12.5 clock_i = ~clock_i;
  end
  epv_unit i_epv_unit (.clock_i(clock_i), .nrst_i(nrst_i), .wdt_overflow_i(wdt),
    .mode_i(mode), .instr_done_i(ev[0]), .instr_rte_i(ev[1]), .flag_and_instr_i(ev[2]),
    .flag_or_instr_i(ev[3]), .flag_xor_instr_i(ev[4]), .flag_load_instr_i(ev[5]),
    .undef_instr_i(ev[6]), .trap_i(ev[7]), .trap_num_i(tnum), .cpu_addr_err_i(ev[8]),
    .sp_set_i(ev[11]), .data_transfer_ctrl_err_i(ev[9]), .dmac_err_i(ev[10]),
    .irq_req_i(irq), .irq_vec_i(ivec), .vbr_wr_i(cfg_wr), .vbr_data_i(vb),
    .exr_wr_i(cfg_wr), .exr_t_i(t_bit), .exr_mask_i(3'h0), .ccr_wr_i(cfg_wr),
    .ccr_mask_i(1'b0), .icm_wr_i(cfg_wr), .icm_i(icm), .stack_done_i(stack_done),
    .fetch_ack_i(fetch_ack), .fetch_data_i(fetch_data), .stack_req_o(stack_req),
    .fetch_req_o(fetch_req), .fetch_addr_o(faddr), .pc_load_o(pc_load),
    .pc_value_o(pc_value), .chip_reset_o(chip_reset), .busy_o(busy), .src_o(src),
    .vec_num_o(vec_num), .irq_blocked_o(blocked), .vector_base_o(vbase),
    .trace_bit_o(t_out), .exr_mask_o(exr_mask), .ccr_mask_o(ccr_mask), .icm_o(icm_out),
    .user_boot_o(ub), .flash_boot_o(fb), .advanced_o(adv), .single_chip_o(sc),
    .rom_enable_o(rom), .mode_bad_o(bad));
  epv_seq_model i_epv_seq_model (.clock_i(clock_i), .nrst_i(nrst_i), .wait_i(dly),
    .stack_req_i(stack_req), .fetch_req_i(fetch_req), .fetch_addr_i(faddr),
    .stack_done_o(stack_done), .fetch_ack_o(fetch_ack), .fetch_data_o(fetch_data));
  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Table address: offset of four bytes per vector, plus base
  function automatic logic [23:0] taddr(input logic [7:0] v, input logic [31:0] b);
    return b[23:0] + {14'h0, v, 2'b00};
  endfunction
  // Pulse a group of sequencer events for one cycle
  task automatic fire(input logic [11:0] f, input logic [1:0] n);
    @(posedge clock_i);
    ev <= f;
    tnum <= n;
    @(posedge clock_i);
    ev <= 12'h000;
  endtask
  // Status register writes in one cycle
  task automatic cfg(input logic [31:0] b, input logic t, input logic [1:0] m);
    @(posedge clock_i);
    cfg_wr <= 1'b1;
    vb <= b;
    t_bit <= t;
    icm <= m;
    @(posedge clock_i);
    cfg_wr <= 1'b0;
    #1;
    chk(vbase, b);
    chk({t_out, icm_out}, {29'h0, t, m});
  endtask
  // Wait for a handler load and check the vector taken
  task automatic take(input logic [7:0] v, input logic [23:0] a, input logic [2:0] s);
    int n = 0;
    while (pc_load !== 1'b1 && n < 60)
    begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (pc_load !== 1'b1)
    begin
      error_cnt++;
      results();
    end
    chk({24'h0, vec_num}, {24'h0, v});
    chk({8'h0, faddr}, {8'h0, a});
    chk({29'h0, src}, {29'h0, s});
    chk(pc_value, {8'hC3, a});
    @(posedge clock_i);
    #1;
    chk({31'h0, busy}, 32'h0);
  endtask
  // No exception may start for a while
  task automatic quiet();
    repeat (6)
    begin
      @(posedge clock_i);
      #1;
      chk({31'h0, busy}, 32'h0);
    end
  endtask
  // Reset pin held low, then reset handling in the given mode
  task automatic rst(input logic [2:0] m, input int cyc);
    @(posedge clock_i);
    nrst_i <= 1'b0;
    mode <= m;
    #1;
    chk({29'h0, chip_reset, stack_req, fetch_req}, 32'h4);
    repeat (cyc) @(posedge clock_i);
    chk(vbase, 32'h0);
    chk({25'h0, exr_mask, ccr_mask, icm_out, blocked}, 32'h79);
    nrst_i <= 1'b1;
    take(8'h00, 24'h0, 3'h1);
    chk({26'h0, bad, ub, fb, adv, sc, rom}, {26'h0, m == 3'h0 || m > 3'h3, m == 3'h1, m == 3'h2,
      {3{m != 3'h0 && m <= 3'h3}}});
  endtask
  // Main sequence
  initial
  begin
    rst(3'h3, 4);
    cfg(32'h00002000, 1'b0, 2'h0);
    for (int k = 0; k < 4; k++)
    begin
      fire(12'h080, k[1:0]);
      take(8'h08 + k[7:0], taddr(8'h08 + k[7:0], vb), 3'h6);
    end
    dly <= 4'h3;
    fire(12'h1C1, 2'h1);
    take(8'h04, taddr(8'h04, vb), 3'h2);
    take(8'h0C, taddr(8'h0C, 32'h0), 3'h4);
    take(8'h09, taddr(8'h09, vb), 3'h6);
    fire(12'h200, 2'h0);
    take(8'h0D, taddr(8'h0D, vb), 3'h4);
    fire(12'h400, 2'h0);
    take(8'h0D, taddr(8'h0D, vb), 3'h4);
    dly <= 4'h0;
    irq <= 1'b1;
    ivec <= 8'h40;
    fire(12'h001, 2'h0);
    quiet();
    fire(12'h800, 2'h0);
    #1;
    chk({31'h0, blocked}, 32'h0);
    for (int k = 2; k < 6; k++)
    begin
      fire(12'h001 | (12'h001 << k), 2'h0);
      quiet();
    end
    foreach (irq_vecs[k])
    begin
      ivec <= irq_vecs[k];
      fire(12'h001, 2'h0);
      take(irq_vecs[k], taddr(irq_vecs[k], vb), 3'h5);
    end
    irq <= 1'b0;
    cfg(32'h00002000, 1'b1, 2'h2);
    fire(12'h001, 2'h0);
    take(8'h05, taddr(8'h05, vb), 3'h3);
    chk({31'h0, t_out}, 32'h0);
    cfg(32'h00002000, 1'b1, 2'h2);
    fire(12'h003, 2'h0);
    quiet();
    cfg(32'h00002000, 1'b1, 2'h0);
    fire(12'h001, 2'h0);
    quiet();
    @(posedge clock_i);
    wdt <= 1'b1;
    @(posedge clock_i);
    wdt <= 1'b0;
    #1;
    chk({31'h0, chip_reset}, 32'h1);
    take(8'h00, 24'h0, 3'h1);
    chk(vbase, 32'h0);
    fire(12'h040, 2'h0);
    rst(3'h4, 20);
    rst(3'h1, 20);
    rst(3'h2, 20);
    results();
  end
endmodule
